/* rtl/rso_pkg.sv */
// Constants and carrier types for the resampler / output / overrange block.
// Assumes one 40 MHz modulator clock domain and a byte-wide register port.
package rso_pkg;

  // Register offsets and reset values
  localparam logic [8:0] ADDR_CODING = 9'h014;
  localparam logic [8:0] ADDR_CLKCTL = 9'h016;
  localparam logic [8:0] ADDR_RATIO  = 9'h101;
  localparam logic [8:0] ADDR_RANGE  = 9'h111;
  localparam logic [7:0] RST_CODING  = 8'h00;
  localparam logic [7:0] RST_CLKCTL  = 8'h00;
  localparam logic [7:0] RST_RATIO   = 8'h00;
  localparam logic [7:0] RST_RANGE   = 8'h00;

  // Field positions
  localparam int SWING_BIT   = 7;
  localparam int EDGE_BIT    = 7;
  localparam int SELF_RESET_ENABLE_BIT = 7;
  localparam int MODE_BIT    = 6;
  localparam int POL_BIT     = 0;

  // Output word codings
  localparam logic [1:0] CODE_OFFSET = 2'h0;
  localparam logic [1:0] CODE_TWOS   = 2'h1;
  localparam logic [1:0] CODE_GRAY   = 2'h2;

  // Resampler: ratio codes count half steps of the modulator clock
  localparam logic [5:0] RATIO_MIN_CODE   = 6'h08;
  localparam logic [6:0] ACC_STEP         = 7'h02;
  localparam int         OUT_RATE_MIN_MSPS = 20;
  localparam int         OUT_RATE_MAX_MSPS = 168;

  // Upsampling FIR taps 0..6 of the nonzero odd-phase set, mirrored
  localparam logic [6:0][15:0] FIR1_C = {16'h4FD1, 16'hE97F, 16'h0992, 16'hFC07,
                                         16'h0169, 16'hFF9F, 16'h000F};
  localparam logic [3:0][15:0] FIR2_C = {16'h1340, 16'hFBF8, 16'h00E3, 16'hFFE5};
  // Centre taps 32768 and 8192 are unity after these shifts
  localparam int FIR1_SHIFT = 15;
  localparam int FIR2_SHIFT = 13;

  // Overrange
  localparam logic [15:0] FULL_SCALE     = 16'h7FFF;
  localparam int          TRIP_LSB_SHIFT = 9;
  localparam logic [4:0]  ANALOG_PERSIST = 5'h10;

  // Timing
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         AUTO_RST_NS   = 1000;
  localparam logic [5:0] AUTO_RST_CYC  =
    6'((AUTO_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int SAMPLE_W   = 16;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } rso_reg_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        data_clock_out;
    logic        flag;
  } rso_out_t;

  typedef enum logic [1:0] {
    AR_IDLE = 2'b01,
    AR_BUSY = 2'b10
  } rso_ar_state_t;

endpackage

/* rtl/rso_fifo.sv */
// Sample FIFO with a registered read port.
// Assumes writer and reader share clk_sys.
`timescale 1ns/100ps
`default_nettype none
module rso_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } rso_fifo_st_t;

  rso_fifo_st_t s;
  rso_fifo_st_t n;
  logic         push;
  logic         load;

  assign in_ready  = s.cnt < (AW + 1)'(DEPTH);
  assign out_valid = s.ov;
  assign out_data  = s.od;

  always_comb begin
    n    = s;
    push = in_valid && in_ready;
    load = (s.cnt != '0) && (!s.ov || out_ready);
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp        = s.wp + AW'(1);
    end
    if (load) begin
      n.od = s.mem[s.rp];
      n.ov = 1'b1;
      n.rp = s.rp + AW'(1);
    end else if (out_ready) begin
      n.ov = 1'b0;
    end
    n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(load);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_fifo_bound: assert property (s.cnt <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");
endmodule
`default_nettype wire

/* rtl/rso_top.sv */
// Resampler, output formatter and overrange logic of the converter back end.
// Assumes decimated 16-bit samples arrive on clk_sys (the modulator clock);
// trip and calibration levels arrive asynchronously from the analog side.
`timescale 1ns/100ps
`default_nettype none
module rso_top (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // Register port
  input  wire rso_pkg::rso_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  // Decimated sample stream
  input  wire logic                  in_valid,
  input  wire logic [15:0]           in_data,
  output logic                       in_ready,
  // Analog side levels
  input  wire logic                  analog_trip_pin,
  input  wire logic                  cal_active_pin,
  // Output pins
  output rso_pkg::rso_out_t          out_pins,
  output logic                       swing_low,
  output logic                       mod_reset
);

  typedef struct packed {
    logic [7:0]              coding;
    logic [7:0]              clkctl;
    logic [7:0]              ratio;
    logic [7:0]              range;
    logic [7:0]              rdata;
    logic [1:0]              sync1;
    logic [1:0]              sync2;
    logic [6:0]              acc;
    logic [4:0]              since;
    logic [1:0]              sub;
    logic [13:0][15:0]       d1;
    logic [7:0][15:0]        d2;
    logic [15:0]             dout;
    logic                    data_clock_out;
    logic                    flag;
    logic [4:0]              atrip_cnt;
    logic [5:0]              rst_cnt;
    logic                    mod_rst;
    rso_pkg::rso_ar_state_t  ar;
  } rso_state_t;

  rso_state_t  s;
  rso_state_t  n;
  logic        fifo_ov;
  logic [15:0] fifo_od;
  logic        fifo_take;
  logic        strobe;
  logic        start_rst;
  logic        dig_trip;
  logic        flag_val;
  logic [5:0]  eff;
  logic [6:0]  acc_sum;
  logic [16:0] s1;
  logic [16:0] s2;
  logic [16:0] mag;
  logic [15:0] lvl;
  logic [15:0] ob_w;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  function automatic logic [16:0] sat16(input logic signed [35:0] v);
    if (v > 36'sh0_0000_7FFF) begin
      return {1'b1, 16'h7FFF};
    end else if (v < 36'shF_FFFF_8000) begin
      return {1'b1, 16'h8000};
    end
    return {1'b0, v[15:0]};
  endfunction

  function automatic logic [16:0] fir1(input logic [13:0][15:0] x);
    logic signed [35:0] a;
    a = '0;
    for (int i = 0; i < 7; i++) begin
      a = a + 36'(signed'(rso_pkg::FIR1_C[i]))
            * (36'(signed'(x[i])) + 36'(signed'(x[13-i])));
    end
    return sat16(a >>> rso_pkg::FIR1_SHIFT);
  endfunction

  function automatic logic [16:0] fir2(input logic [7:0][15:0] x);
    logic signed [35:0] a;
    a = '0;
    for (int i = 0; i < 4; i++) begin
      a = a + 36'(signed'(rso_pkg::FIR2_C[i]))
            * (36'(signed'(x[i])) + 36'(signed'(x[7-i])));
    end
    return sat16(a >>> rso_pkg::FIR2_SHIFT);
  endfunction

  function automatic logic [15:0] encode(input logic [15:0] ob, input logic [1:0] c);
    case (c)
      rso_pkg::CODE_TWOS: return {~ob[15], ob[14:0]};
      rso_pkg::CODE_GRAY: return ob ^ (ob >> 1);
      default:            return ob;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input buffer

  rso_fifo #(
    .W     (rso_pkg::SAMPLE_W),
    .DEPTH (rso_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (in_valid),
    .in_data   (in_data),
    .in_ready  (in_ready),
    .out_valid (fifo_ov),
    .out_data  (fifo_od),
    .out_ready (fifo_take)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n         = s;
    n.sync1   = {cal_active_pin, analog_trip_pin};
    n.sync2   = s.sync1;
    n.mod_rst = 1'b0;

    // Register writes and registered read data
    if (reg_req.wr) begin
      case (reg_req.addr)
        rso_pkg::ADDR_CODING: n.coding = reg_req.wdata;
        rso_pkg::ADDR_CLKCTL: n.clkctl = reg_req.wdata;
        rso_pkg::ADDR_RATIO:  n.ratio  = reg_req.wdata;
        rso_pkg::ADDR_RANGE:  n.range  = reg_req.wdata;
        default:              n.ratio  = s.ratio;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        rso_pkg::ADDR_CODING: n.rdata = s.coding;
        rso_pkg::ADDR_CLKCTL: n.rdata = s.clkctl;
        rso_pkg::ADDR_RATIO:  n.rdata = s.ratio;
        rso_pkg::ADDR_RANGE:  n.rdata = s.range;
        default:              n.rdata = 8'h00;
      endcase
    end

    // Nonzero codes below the minimum all mean a ratio of four
    eff     = (s.ratio[5:0] <= rso_pkg::RATIO_MIN_CODE) ? rso_pkg::RATIO_MIN_CODE
                                                       : s.ratio[5:0];
    acc_sum = s.acc + rso_pkg::ACC_STEP;
    // One strobe per eff/2 clocks; odd codes alternate n and n+1 cycles
    strobe  = (s.ratio[5:0] != 6'h00) && (s.ar == rso_pkg::AR_IDLE)
              && (acc_sum >= {1'b0, eff});

    // Two halfband interpolators, even phase is the centre tap alone
    s1 = s.sub[1] ? fir1(s.d1) : {1'b0, s.d1[6]};
    s2 = s.sub[0] ? fir2(s.d2) : {1'b0, s.d2[3]};
    fifo_take = strobe && (s.sub == 2'h0);

    // Digital trip level is n/64 of full scale for nonzero n with the mode bit clear, else full scale
    lvl = (s.range[5:0] == 6'h00 || s.range[rso_pkg::MODE_BIT])
          ? rso_pkg::FULL_SCALE
          : {1'b0, s.range[5:0], 9'h000};
    mag = s2[15] ? 17'(~{1'b1, s2[15:0]}) + 17'h0_0001 : {1'b0, s2[15:0]};
    dig_trip = s2[16] || (mag > {1'b0, lvl});

    if (!s.range[rso_pkg::MODE_BIT]) begin
      flag_val = dig_trip;
    end else if (s.range[rso_pkg::POL_BIT]) begin
      flag_val = !(dig_trip || s.sync2[0] || s.sync2[1]);
    end else begin
      flag_val = dig_trip || s.sync2[0];
    end

    ob_w = {~s2[15], s2[14:0]};

    if (s.ratio[5:0] == 6'h00) begin
      // Resampler held in reset
      n.acc   = '0;
      n.sub   = '0;
      n.d1    = '0;
      n.d2    = '0;
      n.data_clock_out   = 1'b0;
      n.since = '0;
    end else if (strobe) begin
      n.acc = acc_sum - {1'b0, eff};
      n.sub = s.sub + 2'h1;
      if (fifo_take && fifo_ov) begin
        n.d1 = {s.d1[12:0], fifo_od};
      end
      if (!s.sub[0]) begin
        n.d2 = {s.d2[6:0], s1[15:0]};
      end
      n.dout  = encode(ob_w, s.coding[1:0]);
      n.data_clock_out   = 1'b0;
      n.since = '0;
      n.flag  = flag_val;
    end else if (s.ar == rso_pkg::AR_IDLE) begin
      n.acc   = acc_sum;
      n.since = s.since + 5'h01;
      if (n.since == {1'b0, eff[5:2]}) begin
        n.data_clock_out = 1'b1;
      end
    end

    // Consecutive analog trip cycles, saturating
    if (s.sync2[0]) begin
      n.atrip_cnt = (s.atrip_cnt == rso_pkg::ANALOG_PERSIST) ? s.atrip_cnt
                                                            : s.atrip_cnt + 5'h01;
    end else begin
      n.atrip_cnt = '0;
    end

    start_rst = s.range[rso_pkg::SELF_RESET_ENABLE_BIT] && (s.ar == rso_pkg::AR_IDLE)
                && ((strobe && dig_trip)
                    || (s.sync2[0] && s.atrip_cnt == rso_pkg::ANALOG_PERSIST - 5'h01));

    // Self reset sequencer
    case (s.ar)
      rso_pkg::AR_IDLE: begin
        if (start_rst) begin
          n.ar      = rso_pkg::AR_BUSY;
          n.rst_cnt = rso_pkg::AUTO_RST_CYC - 6'h01;
          n.flag    = 1'b1;
          // Only the analog persistence path pulses the modulator reset
          n.mod_rst = s.sync2[0]
                      && (s.atrip_cnt == rso_pkg::ANALOG_PERSIST - 5'h01);
          n.acc     = '0;
          n.sub     = '0;
          n.d1      = '0;
          n.d2      = '0;
        end
      end
      rso_pkg::AR_BUSY: begin
        n.flag = 1'b1;
        if (s.rst_cnt == 6'h00) begin
          n.ar = rso_pkg::AR_IDLE;
        end else begin
          n.rst_cnt = s.rst_cnt - 6'h01;
        end
      end
      default: n.ar = rso_pkg::AR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s        <= '0;
      s.coding <= rso_pkg::RST_CODING;
      s.clkctl <= rso_pkg::RST_CLKCTL;
      s.ratio  <= rso_pkg::RST_RATIO;
      s.range  <= rso_pkg::RST_RANGE;
      s.ar     <= rso_pkg::AR_IDLE;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata     = s.rdata;
  assign out_pins.data = s.dout;
  assign out_pins.data_clock_out  = s.data_clock_out ^ s.clkctl[rso_pkg::EDGE_BIT];
  assign out_pins.flag = s.flag;
  assign swing_low     = s.coding[rso_pkg::SWING_BIT];
  assign mod_reset     = s.mod_rst;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence seq_quiet3;
    !strobe [*3];
  endsequence

  chk_ratio_zero_idle: assert property (
    (s.ratio[5:0] == 6'h00) |-> !strobe)
    else $error("strobe while resampler held");

  chk_strobe_spacing: assert property (
    strobe |=> seq_quiet3)
    else $error("strobes closer than four clocks");

  chk_ratio_four_rate: assert property (
    (strobe && s.ratio[5:0] != 6'h00 && s.ratio[5:0] <= rso_pkg::RATIO_MIN_CODE
     && s.ar == rso_pkg::AR_IDLE)
    |=> ((($stable(s.ratio) && s.ar == rso_pkg::AR_IDLE) [*4]) |-> strobe))
    else $error("ratio four strobe missing");

  chk_flag_per_sample: assert property (
    $changed(out_pins.flag) |-> ($past(strobe) || $past(s.ar == rso_pkg::AR_BUSY)
                                 || $past(start_rst)))
    else $error("flag changed between samples");

  chk_gray_word: assert property (
    (strobe && s.coding[1:0] == rso_pkg::CODE_GRAY)
    |=> (out_pins.data == ($past(ob_w) ^ ($past(ob_w) >> 1))))
    else $error("gray word wrong");

  chk_analog_persist: assert property (
    mod_reset |-> ($past(s.atrip_cnt) == rso_pkg::ANALOG_PERSIST - 5'h01
                   && $past(s.sync2[0])))
    else $error("modulator reset without 16 trip cycles");

  chk_self_reset_flag: assert property (
    start_rst |=> (out_pins.flag && s.ar == rso_pkg::AR_BUSY) [*8])
    else $error("flag dropped during self reset");

  chk_dco_edge: assert property (
    strobe |=> (out_pins.data_clock_out == s.clkctl[rso_pkg::EDGE_BIT]))
    else $error("data clock wrong level after update");

  chk_full_scale_trip: assert property (
    (strobe && s2[16] && !s.range[rso_pkg::MODE_BIT] && s.ar == rso_pkg::AR_IDLE
     && !start_rst) |=> out_pins.flag)
    else $error("clip not flagged");

endmodule
`default_nettype wire

/* verif/rso_rx_model.sv */
// Receiving logic model: latches the output word on the data clock rise.
// Assumes out_pins of rso_top and a 25 ns clk_sys period.
`timescale 1ns/100ps
`default_nettype none
module rso_rx_model (
  // Output link
  input  wire rso_pkg::rso_out_t out_pins,
  // Capture results
  output var int                 rises,
  output var int                 gap_sum,
  output var logic [15:0]        cap_data,
  output var logic               cap_flag
);
  ////////////////////////////////////////
  realtime t_last;
  int      gap_q;
  int      g;
  initial begin
    rises = 0;
    gap_sum = 0;
    gap_q = 0;
    t_last = 0.0;
    cap_data = 16'h0000;
    cap_flag = 1'b0;
  end
  // Two gaps hold one floor and one ceil spacing on odd codes
  always @(posedge out_pins.data_clock_out) begin
    g = int'(($realtime - t_last) / 25.0);
    gap_sum = gap_q + g;
    gap_q = g;
    t_last = $realtime;
    cap_data = out_pins.data;
    rises++;
  end
  // Flag taken on the falling edge for setup margin
  // Flag launches with the fall, so look a little after it
  always @(negedge out_pins.data_clock_out) #1 cap_flag = out_pins.flag;
endmodule
`default_nettype wire

/* verif/resampler_output_overrange_tb.sv */
// Self-checking bench for the resampler, output coder and range flag.
// Assumes rso_top with the receiver model on its output pins.
`timescale 1ns/100ps
`default_nettype none
module resampler_output_overrange_tb;
  logic                  clk_sys, nrst, in_valid, in_ready, swing_low, mod_reset;
  logic                  analog_trip_pin, cal_active_pin, cap_flag;
  logic [15:0]           in_data, cap_data, x;
  logic [7:0]            reg_rdata, rd, d;
  rso_pkg::rso_reg_req_t reg_req;
  rso_pkg::rso_out_t     out_pins;
  int                    rises, gap_sum, err_total, checks, seed, n;
  logic [8:0]            a_tab [4];
  int                    codes [7];
  logic [24:0]           dig_tab [5];
  logic [10:0]           md_tab [5];
  ////////////////////////////////////////
  rso_top uut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .analog_trip_pin(analog_trip_pin), .cal_active_pin(cal_active_pin),
    .out_pins(out_pins), .swing_low(swing_low), .mod_reset(mod_reset)
  );
  rso_rx_model rx (
    .out_pins(out_pins), .rises(rises), .gap_sum(gap_sum),
    .cap_data(cap_data), .cap_flag(cap_flag)
  );
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_cnt(input int g, input int e);
    checks++;
    if (g != e) begin
      err_total++;
      $display("[ERR] %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] v);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    tick();
    reg_req.wr = 1'b0;
    tick();
  endtask
  task automatic reg_rd(input logic [8:0] a, output logic [7:0] v);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick();
    reg_req.rd = 1'b0;
    v = reg_rdata;
    tick();
  endtask
  // Bound scales with the count so the slowest ratio still fits
  task automatic wait_rises(input int k);
    int r0;
    r0 = rises;
    for (int t = 0; t < 40 * k + 40 && rises < r0 + k; t++) tick();
    if (rises < r0 + k) begin
      err_total++;
      $display("[ERR] %0t data clock stalled", $time);
      test_done();
    end
  endtask
  // New level only after the old word was taken, then let filters settle
  task automatic feed(input logic [15:0] v);
    for (int t = 0; t < 400 && in_ready !== 1'b1; t++) tick();
    cmp_val(16'(in_ready), 16'h0001);
    tick();
    in_data = v;
    in_valid = 1'b1;
    wait_rises(200);
  endtask
  function automatic logic [15:0] coded(input logic [15:0] v, input logic [1:0] m);
    logic [15:0] ob;
    ob = v ^ 16'h8000;
    case (m)
      rso_pkg::CODE_TWOS: return v;
      rso_pkg::CODE_GRAY: return ob ^ (ob >> 1);
      default:            return ob;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    seed = 32'h85f5;
    err_total = 0;
    checks = 0;
    nrst = 1'b0;
    reg_req = '0;
    in_valid = 1'b0;
    in_data = 16'h0000;
    analog_trip_pin = 1'b0;
    cal_active_pin = 1'b0;
    a_tab = '{rso_pkg::ADDR_CODING, rso_pkg::ADDR_CLKCTL,
              rso_pkg::ADDR_RATIO, rso_pkg::ADDR_RANGE};
    codes = '{1, 8, 9, 16, 17, 40, 63};
    dig_tab = '{{8'h20, 16'h4001, 1'b1}, {8'h20, 16'h4000, 1'b0},
                {8'h20, 16'hBFFF, 1'b1}, {8'h00, 16'h7FFE, 1'b0},
                {8'h01, 16'h7FFE, 1'b1}};
    md_tab = '{{8'h40, 3'b000}, {8'h40, 3'b101}, {8'h41, 3'b100},
               {8'h41, 3'b001}, {8'h41, 3'b010}};
    repeat (8) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    tick();
    for (int i = 0; i < 4; i++) begin
      reg_rd(a_tab[i], rd);
      cmp_val({8'h00, rd}, 16'h0000);
    end
    // Ratio 0 after reset holds the resampler, so nothing drains
    n = 0;
    in_valid = 1'b1;
    for (int t = 0; t < 40; t++) begin
      if (in_ready === 1'b1) begin
        n++;
        tick();
        in_data = 16'($random(seed));
      end else begin
        tick();
      end
    end
    cmp_cnt(int'(n >= 16 && n <= 17), 1);
    cmp_val(16'(in_ready), 16'h0000);
    reg_wr(9'h0FF, 8'h5A);
    reg_rd(9'h0FF, rd);
    cmp_val({8'h00, rd}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      reg_wr(a_tab[i], d);
      reg_rd(a_tab[i], rd);
      cmp_val({8'h00, rd}, {8'h00, d});
      if (i == 0) cmp_val(16'(swing_low), 16'(d[7]));
    end
    reg_wr(rso_pkg::ADDR_CODING, 8'h00);
    reg_wr(rso_pkg::ADDR_CLKCTL, 8'h00);
    reg_wr(rso_pkg::ADDR_RANGE, 8'h00);
    reg_wr(rso_pkg::ADDR_RATIO, 8'h00);
    reg_wr(rso_pkg::ADDR_RATIO, 8'h08);
    in_valid = 1'b0;
    wait_rises(100);
    cmp_val(16'(in_ready), 16'h0001);
    for (int i = 0; i < 7; i++) begin
      reg_wr(rso_pkg::ADDR_RATIO, 8'h00);
      reg_wr(rso_pkg::ADDR_RATIO, 8'(codes[i]));
      wait_rises(4);
      cmp_cnt(gap_sum, (codes[i] < 8) ? 8 : codes[i]);
    end
    reg_wr(rso_pkg::ADDR_RATIO, 8'h00);
    repeat (10) tick();
    n = rises;
    repeat (100) tick();
    cmp_cnt(rises - n, 0);
    reg_wr(rso_pkg::ADDR_RATIO, 8'h08);
    x = 16'($random(seed));
    feed(x);
    for (int m = 0; m < 4; m++) begin
      reg_wr(rso_pkg::ADDR_CODING, 8'(m));
      wait_rises(3);
      cmp_val(cap_data, coded(x, 2'(m)));
    end
    reg_wr(rso_pkg::ADDR_CLKCTL, 8'h80);
    wait_rises(4);
    cmp_cnt(gap_sum, 8);
    reg_wr(rso_pkg::ADDR_CLKCTL, 8'h00);
    for (int i = 0; i < 5; i++) begin
      reg_wr(rso_pkg::ADDR_RANGE, dig_tab[i][24:17]);
      feed(dig_tab[i][16:1]);
      cmp_val(16'(cap_flag), 16'(dig_tab[i][0]));
    end
    feed(16'h0100);
    for (int i = 0; i < 5; i++) begin
      reg_wr(rso_pkg::ADDR_RANGE, md_tab[i][10:3]);
      analog_trip_pin = md_tab[i][2];
      cal_active_pin = md_tab[i][1];
      wait_rises(3);
      cmp_val(16'(cap_flag), 16'(md_tab[i][0]));
    end
    cal_active_pin = 1'b0;
    analog_trip_pin = 1'b0;
    reg_wr(rso_pkg::ADDR_RANGE, 8'h80);
    wait_rises(3);
    analog_trip_pin = 1'b1;
    n = 0;
    repeat (16) begin
      tick();
      n += int'(mod_reset === 1'b1);
    end
    cmp_cnt(n, 0);
    n = 0;
    repeat (8) begin
      tick();
      n += int'(mod_reset === 1'b1);
    end
    cmp_cnt(n, 1);
    analog_trip_pin = 1'b0;
    n = 0;
    repeat (20) begin
      tick();
      n += int'(out_pins.flag !== 1'b1);
    end
    cmp_cnt(n, 0);
    wait_rises(8);
    cmp_val(16'(cap_flag), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
